// [dv/config_host_model.sv]
// Purpose: Behavioural configuration host on the far side of the pins.
// Assumes: Link clock period 125 ns, idle low between words.
// Notes:   Released data lines show the inverse of the last word.
module config_host_model (
   output logic config_request_n,
   output logic config_clock,
   output logic [7:0] config_data,
   output logic status_low
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      config_request_n = 1'b0;
      config_clock = 1'b0;
      config_data = 8'h00;
      status_low = 1'b0;
   end
   task automatic hold_request();
      config_request_n <= 1'b0;
   endtask
   task automatic release_request();
      config_request_n <= 1'b1;
   endtask
   task automatic pull_status(input logic v);
      status_low <= v;
   endtask
   // Word held over reps rising edges, so x4 mode sees it on all four
   // Odd tenths keep link edges clear of system clock edges
   task automatic word(input logic [7:0] d, input int reps);
      config_data <= d;
      #20.1;
      repeat (reps) begin
         config_clock = 1'b1;
         #62.5;
         config_clock = 1'b0;
         #62.5;
      end
      config_data = ~d;
      #19.9;
   endtask
endmodule

// [dv/config_scheme_select_por_asserts.sv]
// Purpose: Assertions on the scheme select and power-on reset front end.
// Assumes: Pins reach the logic through two-stage synchronisers.
// Notes:   Windows of a few cycles cover that sync delay.
`include "config_scheme_defines.vh"
module config_scheme_select_por_asserts (
   input wire clk,
   input wire rst_n,
   input wire supply_good,
   input wire config_request_n,
   input wire jtag_config_req,
   input wire status_oe_n,
   input wire por_reset_n_ff,
   input wire core_reset_n_ff,
   input wire [2:0] scheme_code_ff,
   input wire scheme_ok_ff,
   input wire decode_allow_ff,
   input wire as_clock_ff,
   input wire word_strobe_ff,
   input wire s_axi_awready,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   brownout_reset_a: assert property (
      $fell(supply_good) |-> ##[1:6] !por_reset_n_ff)
      else $error("brown-out left reset released");
   por_status_a: assert property (
      !por_reset_n_ff && !$past(por_reset_n_ff) |-> !status_oe_n)
      else $error("status released during power-on reset");
   request_hold_a: assert property (
      !config_request_n [*6] |-> !core_reset_n_ff)
      else $error("core released while request low");
   jtag_scheme_a: assert property (
      jtag_config_req [*5] ##0 por_reset_n_ff |->
      scheme_code_ff == `SCHEME_JTAG)
      else $error("boundary-scan scheme not shown");
   jtag_nodecode_a: assert property (
      jtag_config_req [*5] |-> !decode_allow_ff)
      else $error("decode allowed on boundary-scan load");
   capture_gate_a: assert property (
      word_strobe_ff |-> core_reset_n_ff && scheme_ok_ff &&
      scheme_code_ff != `SCHEME_ACTIVE)
      else $error("word captured outside a capturing scheme");
   unsupported_a: assert property (
      !scheme_ok_ff |-> !decode_allow_ff)
      else $error("decode allowed on unsupported scheme");
   as_clock_a: assert property (
      $rose(as_clock_ff) |-> scheme_code_ff == `SCHEME_ACTIVE ##1
      as_clock_ff [*2] ##1 !as_clock_ff)
      else $error("serial clock high phase wrong");
   write_busy_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_busy_a: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
endmodule

bind config_scheme_select_por config_scheme_select_por_asserts
   config_scheme_select_por_asserts_i (.*);

// [dv/config_scheme_select_por_bench.sv]
// Purpose: Self-checking bench of the scheme select and reset front end.
// Assumes: Host model drives the link pins on its own 125 ns clock.
// Notes:   Short reset delays keep the run brief.
`include "config_scheme_defines.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   errors++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(c) begin for (n = 0; n < 400 && !(c); n++) @(negedge clk); \
   if (!(c)) begin errors++; conclude(); end end
module config_scheme_select_por_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STD = 40;
   localparam int FAST = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] scheme_select_pins = 3'h0;
   logic reset_delay_select = 1'b1;
   logic supply_good = 1'b0;
   logic jtag_config_req = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   wire config_request_n, config_clock, status_low, status_out, status_oe_n;
   wire [7:0] config_data, word_ff;
   wire [2:0] scheme_code_ff;
   wire por_reset_n_ff, core_reset_n_ff, scheme_ok_ff, decode_allow_ff;
   wire as_clock_ff, word_strobe_ff, s_axi_awready, s_axi_wready;
   wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   // Open-drain status wire with pull-up
   wire status_in = status_oe_n ? ~status_low : status_out;
   int errors = 0;
   int total_checks = 0;
   int n;
   logic [31:0] seed = 32'h0000A9C6;
   logic [7:0] wq[$];
   logic [33:0] rq[$];
   logic [8:0] ew;
   logic [33:0] er;
   always #2 clk = ~clk;
   config_scheme_select_por #(.POR_STD_CYCLES(STD), .POR_FAST_CYCLES(FAST))
      config_scheme_select_por_i (.*);
   config_host_model config_host_model_i (.*);
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ****************************************
   // Result watcher
   // ****************************************
   always @(negedge clk) begin
      if (word_strobe_ff === 1'b1) begin
         ew = wq.size() ? {1'b0, wq.pop_front()} : 9'h100;
         `CHK("word", ew, {1'b0, word_ff})
      end
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         er = rq.pop_front();
         `CHK("read", er, {s_axi_rresp, s_axi_rdata})
      end
   end
   task automatic axw(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] eb);
      logic aw, w, b;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(negedge clk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) begin
            s_axi_bready <= 1'b0;
            `CHK("bresp", eb, s_axi_bresp)
            return;
         end
      end
      errors++;
      conclude();
   endtask
   task automatic axr(input logic [3:0] a, input logic [33:0] e);
      logic ar, r;
      rq.push_back(e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int k = 0; k < 50; k++) begin
         @(negedge clk);
         ar = s_axi_arvalid & s_axi_arready;
         r = s_axi_rvalid;
         @(posedge clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) begin
            s_axi_rready <= 1'b0;
            return;
         end
      end
      errors++;
      conclude();
   endtask
   task automatic enter(input logic [2:0] c);
      @(posedge clk);
      scheme_select_pins <= c;
      config_host_model_i.hold_request();
      repeat (8) @(posedge clk);
      `CHK("core reset", 1'b0, core_reset_n_ff)
      config_host_model_i.release_request();
      `WAITC(status_oe_n === 1'b1)
      repeat (6) @(posedge clk);
   endtask
   initial begin
      logic [7:0] d;
      int lim, m;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      // Fast delay first, then brown-out and standard delay
      for (int f = 1; f >= 0; f--) begin
         @(posedge clk);
         supply_good <= 1'b0;
         reset_delay_select <= f[0];
         `WAITC(por_reset_n_ff === 1'b0)
         repeat (4) @(posedge clk);
         supply_good <= 1'b1;
         for (n = 0; n < 200 && por_reset_n_ff !== 1'b1; n++) @(negedge clk);
         lim = f ? FAST : STD;
         `CHK("por delay", 1'b1, n >= lim && n <= lim + 8)
      end
      axr(`ADDR_CONTROL, {2'h0, 32'h00000002});
      axr(4'hC, {2'h3, 32'h0});
      axw(4'hC, 32'h0, 2'h3);
      for (int c = 0; c < 8; c++) begin
         enter(c[2:0]);
         `CHK("scheme ok", c < 4, scheme_ok_ff)
         @(posedge clk);
         scheme_select_pins <= ~c[2:0];
         for (int k = 0; k < 3; k++) begin
            d = rnd();
            if (c == 0 || c == 1) wq.push_back(d);
            if (c == 2) wq.push_back({7'h00, d[0]});
            config_host_model_i.word(d, c == 1 ? 4 : 1);
         end
         repeat (6) @(posedge clk);
         if (c < 4) begin
            `CHK("scheme", c[2:0], scheme_code_ff)
            axr(`ADDR_STATUS, {24'h0, 2'h3, 1'b0, 4'hD, c[2:0]});
            axr(`ADDR_WORDS, {18'h0, (c == 3) ? 16'h0 : 16'h3});
         end
         if (c == 3) begin
            m = 0;
            repeat (70) begin
               @(negedge clk);
               m += (as_clock_ff === 1'b1);
            end
            `CHK("serial clock high", 30, m)
         end
      end
      enter(`SCHEME_SERIAL);
      jtag_config_req <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("jtag scheme", `SCHEME_JTAG, scheme_code_ff)
      `CHK("jtag decode", 1'b0, decode_allow_ff)
      config_host_model_i.word(rnd(), 1);
      @(posedge clk);
      jtag_config_req <= 1'b0;
      scheme_select_pins <= `SCHEME_PARALLEL;
      axw(`ADDR_CONTROL, 32'h00000003, 2'h0);
      `WAITC(status_oe_n === 1'b0)
      `WAITC(core_reset_n_ff === 1'b1)
      `CHK("reconfig scheme", `SCHEME_PARALLEL, scheme_code_ff)
      config_host_model_i.pull_status(1'b1);
      repeat (8) @(posedge clk);
      `CHK("status low", 1'b0, core_reset_n_ff)
      config_host_model_i.pull_status(1'b0);
      supply_good <= 1'b0;
      `WAITC(por_reset_n_ff === 1'b0)
      `CHK("brown-out status", 1'b0, status_oe_n)
      `CHK("words left", 0, wq.size())
      conclude();
   end
endmodule

// [hdl/config_scheme_defines.vh]
// Purpose: Shared constants of the configuration scheme front end.
// Assumes: 250 MHz system clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef CONFIG_SCHEME_DEFINES_VH
`define CONFIG_SCHEME_DEFINES_VH

// ****************************************
// Scheme codes
// ****************************************
`define SCHEME_PARALLEL    3'h0
`define SCHEME_PARALLEL_X4 3'h1
`define SCHEME_SERIAL      3'h2
`define SCHEME_ACTIVE      3'h3
// Boundary-scan code; pins 111 also latch this value, flagged unsupported
`define SCHEME_JTAG        3'h7

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ADDR_STATUS  4'h0
`define ADDR_CONTROL 4'h4
`define ADDR_WORDS   4'h8

// ****************************************
// Field positions and reset values
// ****************************************
`define ST_SCHEME_LSB   0
`define ST_VALID_BIT    3
`define ST_JTAG_BIT     4
`define ST_DECODE_BIT   5
`define ST_PORDONE_BIT  6
`define ST_FAST_BIT     7
`define ST_STATE_LSB    8
`define CTL_RECONF_BIT  0
`define CTL_ASCLK_BIT   1
`define CTL_RESET       2'h2

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ          250
`define POR_STD_MS       200
`define POR_FAST_MS      8
`define POR_STD_CYCLES   (`POR_STD_MS * 1000 * `CLK_MHZ)
`define POR_FAST_CYCLES  (`POR_FAST_MS * 1000 * `CLK_MHZ)
`define AS_CLK_MHZ       40
`define AS_PERIOD_CYCLES ((`CLK_MHZ + `AS_CLK_MHZ - 1) / `AS_CLK_MHZ)

`endif

// [hdl/config_scheme_select_por.v]
// Purpose: Scheme decode, power-on reset timing and reset stage control.
// Assumes: All pin inputs are asynchronous; AXI4-Lite on clk.
// Notes:   Per-scheme data handling beyond word capture is outside.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`include "config_scheme_defines.vh"

module config_scheme_select_por #(
   parameter [31:0] POR_STD_CYCLES = `POR_STD_CYCLES,
   parameter [31:0] POR_FAST_CYCLES = `POR_FAST_CYCLES
) (
   input wire clk,
   input wire rst_n,
   input wire [2:0] scheme_select_pins,
   input wire reset_delay_select,
   input wire supply_good,
   input wire config_request_n,
   input wire config_clock,
   input wire [7:0] config_data,
   input wire jtag_config_req,
   input wire status_in,
   output wire status_out,
   output wire status_oe_n,
   output reg por_reset_n_ff,
   output reg core_reset_n_ff,
   output reg [2:0] scheme_code_ff,
   output reg scheme_ok_ff,
   output reg decode_allow_ff,
   output reg as_clock_ff,
   output reg [7:0] word_ff,
   output reg word_strobe_ff,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_POR = 2'h0;
   localparam ST_RESET = 2'h1;
   localparam ST_WAIT_STATUS = 2'h2;
   localparam ST_CONFIG = 2'h3;
   localparam [31:0] AS_PERIOD = `AS_PERIOD_CYCLES;
   localparam [31:0] AS_LAST_W = AS_PERIOD - 32'h0000_0001;
   localparam [31:0] AS_HIGH_W = AS_PERIOD / 32'h0000_0002;
   localparam [2:0] AS_LAST = AS_LAST_W[2:0];
   localparam [2:0] AS_HIGH = AS_HIGH_W[2:0];

   // ****************************************
   // Pin synchronisation
   // ****************************************
   wire [2:0] sel_s;
   wire delay_sel_s;
   wire supply_ok_s;
   wire req_n_s;
   wire cclk_s;
   wire jtag_s;
   wire status_s;
   wire [7:0] data_s;

   sync2 #(.WIDTH(17)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({scheme_select_pins, reset_delay_select, supply_good,
          config_request_n, config_clock, jtag_config_req, status_in,
          config_data}),
      .q({sel_s, delay_sel_s, supply_ok_s, req_n_s, cclk_s, jtag_s,
          status_s, data_s})
   );

   reg cclk_prev_ff;
   wire cclk_rise = cclk_s && !cclk_prev_ff;

   // ****************************************
   // Register file state
   // ****************************************
   reg [1:0] ctl_ff;
   reg reconf_ff;
   reg [15:0] words_ff;

   // ****************************************
   // Power-on reset timing
   // ****************************************
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg por_fast_ff;
   wire por_done;

   // Delay chosen by the select pin before counting starts
   wire [31:0] por_load = por_fast_ff ? POR_FAST_CYCLES :
                          POR_STD_CYCLES;

   por_timer u_por (
      .clk(clk),
      .rst_n(rst_n),
      .clear(!supply_ok_s),
      .run(state_ff == ST_POR),
      .load(por_load),
      .done(por_done)
   );

   // ****************************************
   // Stage control
   // ****************************************
   always @* begin
      nxt_state = state_ff;
      if (!supply_ok_s) begin
         nxt_state = ST_POR;
      end else begin
         case (state_ff)
            ST_POR: begin
               if (por_done) begin
                  nxt_state = ST_RESET;
               end
            end
            ST_RESET: begin
               if (req_n_s && !reconf_ff) begin
                  nxt_state = ST_WAIT_STATUS;
               end
            end
            ST_WAIT_STATUS: begin
               if (!req_n_s) begin
                  nxt_state = ST_RESET;
               end else if (status_s) begin
                  nxt_state = ST_CONFIG;
               end
            end
            ST_CONFIG: begin
               if (!req_n_s || !status_s || reconf_ff) begin
                  nxt_state = ST_RESET;
               end
            end
            default: begin
               nxt_state = ST_POR;
            end
         endcase
      end
   end

   // Open-drain status: only ever pulls low
   assign status_out = 1'b0;
   assign status_oe_n = !(state_ff == ST_POR ||
                          state_ff == ST_RESET);

   // ****************************************
   // Scheme latch and decode
   // ****************************************
   reg [2:0] scheme_ff;
   reg scheme_valid_ff;
   reg [1:0] phase_ff;
   reg [2:0] as_cnt_ff;
   wire [2:0] eff_scheme = jtag_s ? `SCHEME_JTAG : scheme_ff;
   wire eff_valid = jtag_s || scheme_valid_ff;
   wire loading = state_ff == ST_CONFIG && nxt_state == ST_CONFIG &&
                  !jtag_s && scheme_valid_ff;
   wire take_parallel = loading && (scheme_ff == `SCHEME_PARALLEL ||
                        scheme_ff == `SCHEME_SERIAL);
   wire take_x4 = loading && scheme_ff == `SCHEME_PARALLEL_X4;
   wire as_run = loading && scheme_ff == `SCHEME_ACTIVE &&
                 ctl_ff[`CTL_ASCLK_BIT];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_POR;
         por_fast_ff <= 1'b0;
         scheme_ff <= `SCHEME_PARALLEL;
         scheme_valid_ff <= 1'b0;
         cclk_prev_ff <= 1'b0;
         phase_ff <= 2'h0;
         as_cnt_ff <= 3'h0;
         por_reset_n_ff <= 1'b0;
         core_reset_n_ff <= 1'b0;
         scheme_code_ff <= `SCHEME_PARALLEL;
         scheme_ok_ff <= 1'b0;
         decode_allow_ff <= 1'b0;
         as_clock_ff <= 1'b0;
         word_ff <= 8'h00;
         word_strobe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cclk_prev_ff <= cclk_s;
         // Hold the choice once counting is under way
         if (state_ff == ST_POR && !supply_ok_s) begin
            por_fast_ff <= delay_sel_s;
         end
         // Latch at release of power-on reset or reconfiguration
         if (state_ff == ST_RESET && nxt_state == ST_WAIT_STATUS) begin
            scheme_ff <= sel_s;
            scheme_valid_ff <= (sel_s[2] == 1'b0);
         end
         por_reset_n_ff <= (nxt_state != ST_POR);
         core_reset_n_ff <= (nxt_state == ST_CONFIG);
         scheme_code_ff <= eff_scheme;
         scheme_ok_ff <= eff_valid;
         // Boundary-scan loads bypass decryption and decompression
         decode_allow_ff <= scheme_valid_ff && !jtag_s;
         // x4 mode: word on first of four rises, others idle
         if (!take_x4) begin
            phase_ff <= 2'h0;
         end else if (cclk_rise) begin
            phase_ff <= phase_ff + 2'h1;
         end
         word_strobe_ff <= cclk_rise &&
                           (take_parallel || (take_x4 && phase_ff == 2'h0));
         if (cclk_rise && take_parallel && scheme_ff == `SCHEME_SERIAL) begin
            word_ff <= {7'h00, data_s[0]};
         end else if (cclk_rise &&
                      (take_parallel || (take_x4 && phase_ff == 2'h0))) begin
            word_ff <= data_s;
         end
         // At most 40 MHz; a started period runs out, so no runt pulse
         if ((!as_run && as_cnt_ff == 3'h0) || as_cnt_ff == AS_LAST) begin
            as_cnt_ff <= 3'h0;
         end else begin
            as_cnt_ff <= as_cnt_ff + 3'h1;
         end
         as_clock_ff <= (as_run || as_cnt_ff != 3'h0) &&
                        (as_cnt_ff < AS_HIGH);
      end
   end

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   reg aw_got_ff;
   reg w_got_ff;
   reg [3:0] aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;

   assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
   wire [31:0] status_word = {22'h000000, state_ff, por_fast_ff,
                              por_reset_n_ff, decode_allow_ff, jtag_s,
                              scheme_valid_ff, scheme_ff};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         ctl_ff <= `CTL_RESET;
         reconf_ff <= 1'b0;
         words_ff <= 16'h0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         // Request drops once the stage machine has acted on it
         if (reconf_ff && state_ff == ST_RESET) begin
            reconf_ff <= 1'b0;
         end
         if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_ff == `ADDR_CONTROL) begin
               s_axi_bresp <= 2'h0;
               if (w_strb_ff[0]) begin
                  ctl_ff[`CTL_ASCLK_BIT] <= w_data_ff[`CTL_ASCLK_BIT];
                  if (w_data_ff[`CTL_RECONF_BIT]) begin
                     reconf_ff <= 1'b1;
                  end
               end
            end else if (aw_addr_ff == `ADDR_STATUS ||
                         aw_addr_ff == `ADDR_WORDS) begin
               s_axi_bresp <= 2'h0;
            end else begin
               s_axi_bresp <= 2'h3;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr)
               `ADDR_STATUS: s_axi_rdata <= status_word;
               `ADDR_CONTROL: s_axi_rdata <= {30'h00000000, ctl_ff};
               `ADDR_WORDS: s_axi_rdata <= {16'h0000, words_ff};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= 2'h3;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         // Word count restarts with every reset stage
         if (state_ff != ST_CONFIG && state_ff != ST_WAIT_STATUS) begin
            words_ff <= 16'h0000;
         end else if (word_strobe_ff) begin
            words_ff <= words_ff + 16'h0001;
         end
      end
   end
endmodule

// [hdl/por_timer.v]
// Purpose: Delay counter for the power-on reset time.
// Assumes: load is stable while run is high.
// Notes:   done stays high until clear.
module por_timer (
   input wire clk,
   input wire rst_n,
   input wire clear,
   input wire run,
   input wire [31:0] load,
   output wire done
);
   reg [31:0] cnt_ff;
   reg done_ff;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 32'h0000_0000;
         done_ff <= 1'b0;
      end else if (clear) begin
         cnt_ff <= 32'h0000_0000;
         done_ff <= 1'b0;
      end else if (run && !done_ff) begin
         cnt_ff <= cnt_ff + 32'h0000_0001;
         if (cnt_ff == load - 32'h0000_0001) begin
            done_ff <= 1'b1;
         end
      end
   end

   assign done = done_ff;
endmodule

// [hdl/sync2.v]
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous levels.
// Notes:   Only the second stage leaves this module.
module sync2 #(
   parameter WIDTH = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule
